// ===== rtl/fb_image_supervisor.sv
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module fb_image_supervisor
  import fb_image_pkg::*;
#(
  parameter longint SCAN_CYCLES = SCAN_CYC,
  parameter longint WAIT_CYCLES = LINK_WAIT_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  // fieldbus slave interface side
  input wire logic data_exchange_active,
  input wire logic bus_out_we,
  input wire logic [5:0] bus_out_addr,
  input wire logic [7:0] bus_out_data,
  input wire logic [5:0] bus_in_addr,
  output logic [7:0] bus_in_data,
  // robot side word access
  input wire logic [3:0] word_idx,
  input wire logic word_we,
  input wire logic [15:0] word_wdata,
  input wire logic word_re,
  output logic [15:0] word_rdata,
  output logic [31:0] dword_rdata,
  output logic word_err,
  // robot side bit byte access
  input wire logic [3:0] bit_idx,
  input wire logic bit_we,
  input wire logic [7:0] bit_wdata,
  input wire logic bit_re,
  output logic [7:0] bit_rdata,
  input wire logic internal_access,
  // safety pins and parameters
  input wire logic safety_estop_n,
  input wire logic parallel_interlock_input,
  input wire logic safety_service,
  input wire logic monitor_24v_valid,
  input wire logic safe_mode,
  input wire logic servo_on_req,
  // status
  output safety_s safety,
  output logic servo_enable,
  output link_state_e link_state,
  output logic link_error,
  output logic history_pulse,
  output logic scan_tick
);

  localparam int SW = 32;

  link_state_e state_r;
  link_state_e state_nxt;
  logic [SW-1:0] scan_cnt_r;
  logic [SW-1:0] wait_cnt_r;
  logic [3:0] pin_lvl;
  logic [5:0] in_rd_addr;
  logic ctrl_rd_r;
  logic estop_pin_s;
  logic ilk_pin_s;
  logic svc_pin_s;
  logic dx_s;
  logic tick;
  logic [7:0] ctrl_in_r;
  logic servo_r;
  logic word_pend_r;
  logic word_hi_r;
  logic [15:0] word_lo_r;
  logic bit_pend_r;
  byte_req_s in_wr;
  byte_req_s out_wr;
  logic [5:0] out_rd_addr;
  logic [7:0] out_rd_data;
  logic [7:0] in_rd_data;

  // byte offset of a word byte, bit byte and reserved check
  function automatic logic [5:0] word_off(input logic [3:0] k,
                                          input logic hi);
    word_off = WORD_BASE + {1'b0, k, 1'b0} + {5'h00, ~hi};
  endfunction

  function automatic logic [5:0] bit_off(input logic [3:0] k);
    bit_off = BIT_BASE + {2'b00, k};
  endfunction

  function automatic logic reserved(input logic [5:0] a);
    reserved = (a >= RSV_BASE);
  endfunction

  // error states of the link supervisor
  function automatic logic link_err(input link_state_e s);
    link_err = (s == ST_PWR_FAIL) || (s == ST_LOST);
  endfunction

  pin_sync #(.W(4)) u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .pin({data_exchange_active, safety_service,
          parallel_interlock_input, safety_estop_n}),
    .level(pin_lvl)
  );

  // pin order: exchange indication, service, interlock, stop
  assign {dx_s, svc_pin_s, ilk_pin_s, estop_pin_s} = pin_lvl;

  // scan period counter
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      scan_cnt_r <= '0;
    end else if (tick) begin
      scan_cnt_r <= '0;
    end else begin
      scan_cnt_r <= scan_cnt_r + 1'b1;
    end
  end
  assign tick = (scan_cnt_r == SW'(SCAN_CYCLES - 1));

  // link supervisor next state, evaluated once per scan
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_WAIT: begin
        if (dx_s) begin
          state_nxt = ST_NORMAL;
        end else if (wait_cnt_r >= SW'(WAIT_CYCLES)) begin
          state_nxt = ST_PWR_FAIL;
        end
      end
      ST_PWR_FAIL: begin
        if (dx_s) begin
          state_nxt = ST_NORMAL;
        end
      end
      ST_NORMAL: begin
        if (!dx_s) begin
          state_nxt = ST_LOST;
        end
      end
      ST_LOST: begin
        if (dx_s) begin
          state_nxt = ST_NORMAL;
        end
      end
      default: state_nxt = ST_WAIT;
    endcase
  end

  // state register and power-on wait counter
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_r <= ST_WAIT;
      wait_cnt_r <= '0;
    end else begin
      if (state_r == ST_WAIT) begin
        wait_cnt_r <= wait_cnt_r + 1'b1;
      end
      if (tick) begin
        state_r <= state_nxt;
      end
    end
  end

  // link status outputs and history event on error entry
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      link_state <= ST_WAIT;
      link_error <= 1'b0;
      history_pulse <= 1'b0;
      scan_tick <= 1'b0;
    end else begin
      link_state <= state_r;
      link_error <= link_err(state_r);
      // pulse in the same cycle as the error flag rises
      history_pulse <= link_err(state_r) && !link_error;
      scan_tick <= tick;
    end
  end

  // master output bytes accepted only in the normal state
  always_comb begin
    in_wr.we = bus_out_we && (state_r == ST_NORMAL) &&
               !reserved(bus_out_addr);
    in_wr.addr = bus_out_addr;
    in_wr.data = bus_out_data;
  end

  // shared read port: word access, then bit byte read, else control byte
  always_comb begin
    in_rd_addr = BIT_BASE;
    if (word_we || word_re) begin
      in_rd_addr = word_off(word_idx, word_hi_r);
    end else if (bit_re) begin
      in_rd_addr = bit_off(bit_idx);
    end
  end

  image_ram #(.DEPTH(IMG_BYTES)) u_in_ram (
    .clk_sys(clk_sys),
    .wr(in_wr),
    .rd_addr(in_rd_addr),
    .rd_data(in_rd_data)
  );

  // robot side writes into the output image; internal writes command area
  always_comb begin
    out_wr.we = 1'b0;
    out_wr.addr = bit_off(bit_idx);
    out_wr.data = bit_wdata;
    if (word_we && (internal_access ||
                    word_off(word_idx, 1'b1) > CMD_WORD_LAST)) begin
      out_wr.we = 1'b1;
      out_wr.addr = word_off(word_idx, word_hi_r);
      out_wr.data = word_hi_r ? word_wdata[15:8] : word_wdata[7:0];
    end else if (bit_we && !reserved(bit_off(bit_idx)) &&
                 (internal_access ||
                  bit_off(bit_idx) > CTRL_BYTE_LAST)) begin
      out_wr.we = 1'b1;
    end
  end

  // master input image passed on every cycle in the normal state, zero in other states and for reserved bytes
  assign out_rd_addr = bus_in_addr;
  image_ram #(.DEPTH(IMG_BYTES)) u_out_ram (
    .clk_sys(clk_sys),
    .wr(out_wr),
    .rd_addr(out_rd_addr),
    .rd_data(out_rd_data)
  );

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bus_in_data <= 8'h00;
    end else if (state_r != ST_NORMAL || reserved(bus_in_addr)) begin
      bus_in_data <= 8'h00;
    end else begin
      bus_in_data <= out_rd_data;
    end
  end

  // two byte sequencing of word accesses: high byte first then low
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      word_hi_r <= 1'b1;
      word_pend_r <= 1'b0;
      word_lo_r <= 16'h0000;
    end else begin
      word_pend_r <= word_re;
      if (word_we || word_re) begin
        word_hi_r <= ~word_hi_r;
      end
      if (word_pend_r) begin
        if (!word_hi_r) begin
          word_lo_r[15:8] <= in_rd_data;
        end else begin
          word_lo_r[7:0] <= in_rd_data;
        end
      end
    end
  end

  // word read result: unsigned word, signed pair from words k and k+1
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      word_rdata <= 16'h0000;
      dword_rdata <= 32'h00000000;
      word_err <= 1'b0;
    end else begin
      word_err <= (word_we || word_re) && !internal_access &&
                  (word_off(word_idx, 1'b1) <= CMD_WORD_LAST);
      word_rdata <= word_lo_r;
      if (word_idx[0] == 1'b0) begin
        dword_rdata[15:0] <= word_lo_r;
      end else begin
        dword_rdata[31:16] <= word_lo_r;
      end
    end
  end

  // bit byte read, delayed one cycle behind the memory
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bit_pend_r <= 1'b0;
      bit_rdata <= 8'h00;
      ctrl_rd_r <= 1'b0;
    end else begin
      bit_pend_r <= bit_re && !(word_we || word_re);
      ctrl_rd_r <= !(word_we || word_re || bit_re);
      if (bit_pend_r) begin
        bit_rdata <= in_rd_data;
      end
    end
  end

  // capture dedicated control byte at each scan in the normal state when the read port was idle the cycle before, forced on link loss
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_in_r <= 8'h00;
    end else if (state_r == ST_LOST) begin
      ctrl_in_r[ESTOP_BIT] <= 1'b0;
      ctrl_in_r[SVC_BIT] <= 1'b0;
    end else if (tick && ctrl_rd_r && state_r == ST_NORMAL) begin
      ctrl_in_r <= in_rd_data;
    end
  end

  // safety gating
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      safety <= '0;
    end else begin
      safety.estop_n <= estop_pin_s &&
        ((state_r == ST_PWR_FAIL || state_r == ST_WAIT) ||
         ctrl_in_r[ESTOP_BIT]);
      safety.interlock_n <= (!monitor_24v_valid || ilk_pin_s);
      safety.service <= safe_mode &&
        (ctrl_in_r[SVC_BIT] ||
         (monitor_24v_valid && svc_pin_s));
    end
  end

  // servo comes up disabled and is set while servo_on_req is high, cleared by stop or interlock
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      servo_r <= 1'b0;
      servo_enable <= 1'b0;
    end else begin
      if (!safety.estop_n || !safety.interlock_n) begin
        servo_r <= 1'b0;
      end else if (servo_on_req) begin
        servo_r <= 1'b1;
      end
      servo_enable <= servo_r;
    end
  end
endmodule

// ===== rtl/fb_image_pkg.sv
package fb_image_pkg;

  // image geometry, in bytes, relative to the master start address
  localparam int IMG_BYTES = 48;
  localparam int WORD_COUNT = 16;
  localparam int BIT_BYTES = 14;
  localparam logic [5:0] WORD_BASE = 6'h00;
  localparam logic [5:0] BIT_BASE = 6'h20;
  localparam logic [5:0] RSV_BASE = 6'h2e;
  localparam logic [5:0] RSV_LAST = 6'h2f;
  localparam logic [5:0] CMD_WORD_LAST = 6'h03;
  localparam logic [5:0] CTRL_BYTE_LAST = 6'h21;

  // bit positions inside the first input bit byte
  localparam int ESTOP_BIT = 0;
  localparam int SVC_BIT = 2;

  // timing
  localparam longint CLK_HZ = 125000000;
  localparam longint SCAN_MS = 10;
  localparam longint LINK_WAIT_MS = 5000;
  localparam longint SCAN_CYC = CLK_HZ / 1000 * SCAN_MS;
  localparam longint LINK_WAIT_CYC = CLK_HZ / 1000 * LINK_WAIT_MS;

  // link supervisor states
  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_PWR_FAIL = 2'b01,
    ST_NORMAL = 2'b10,
    ST_LOST = 2'b11
  } link_state_e;

  // safety inputs after gating
  typedef struct packed {
    logic estop_n;
    logic interlock_n;
    logic service;
  } safety_s;

  // one byte access to the image memories
  typedef struct packed {
    logic we;
    logic [5:0] addr;
    logic [7:0] data;
  } byte_req_s;

endpackage

// ===== rtl/image_ram.sv
`timescale 1ns/1ps
module image_ram
  import fb_image_pkg::*;
#(
  parameter int DEPTH = 48
) (
  input wire logic clk_sys,
  input wire byte_req_s wr,
  input wire logic [5:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:DEPTH-1];

  // byte write port
  always_ff @(posedge clk_sys) begin
    if (wr.we) begin
      mem[wr.addr] <= wr.data;
    end
  end

  // registered read port
  always_ff @(posedge clk_sys) begin
    rd_data <= mem[rd_addr];
  end
endmodule

// ===== rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // three stage chain, change accepted when stages two and three agree
  always_ff @(posedge clk_sys) begin
    s1_r <= pin;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      level <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          level[i] <= s3_r[i];
        end
      end
    end
  end
endmodule

// ===== testbench/fb_image_props.sv
`timescale 1ns/1ps
module fb_image_props
  import fb_image_pkg::*;
#(
  parameter longint SCAN_CYCLES = SCAN_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [5:0] bus_in_addr,
  input wire logic [7:0] bus_in_data,
  input wire logic safety_estop_n,
  input wire safety_s safety,
  input wire link_state_e link_state,
  input wire logic link_error,
  input wire logic history_pulse,
  input wire logic scan_tick
);
  longint gap_r;
  logic seen_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // cycles since the last scan tick
  always_ff @(posedge clk_sys) begin
    gap_r <= (srst || scan_tick) ? 0 : gap_r + 1;
    seen_r <= !srst && (seen_r || scan_tick);
  end
  property p_scan;
    scan_tick && seen_r |-> gap_r == SCAN_CYCLES - 1;
  endproperty
  a_scan: assert property (p_scan) else $error("scan period");
  property p_rsv;
    (bus_in_addr >= RSV_BASE) [*2] |-> ##1 bus_in_data == 8'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved read");
  property p_nodat;
    (link_state != ST_NORMAL) [*3] |-> bus_in_data == 8'h00;
  endproperty
  a_nodat: assert property (p_nodat) else $error("data in error");
  property p_hist;
    $rose(link_error) |-> ##[0:2] history_pulse;
  endproperty
  a_hist: assert property (p_hist) else $error("no history");
  property p_pin;
    !safety_estop_n [*6] |-> !safety.estop_n;
  endproperty
  a_pin: assert property (p_pin) else $error("pin stop lost");
  property p_lost;
    (link_state == ST_LOST) [*3] |-> !safety.estop_n;
  endproperty
  a_lost: assert property (p_lost) else $error("lost not stop");
  property p_pwr;
    (link_state == ST_PWR_FAIL && safety_estop_n) [*6] |-> safety.estop_n;
  endproperty
  a_pwr: assert property (p_pwr) else $error("pfail stop");
  property p_norm;
    (link_state == ST_NORMAL) [*2] |-> !link_error;
  endproperty
  a_norm: assert property (p_norm) else $error("error in normal");
  c_lost: cover property (link_state == ST_LOST);
  c_pwr: cover property (link_state == ST_PWR_FAIL);
  c_hist: cover property (history_pulse);
endmodule
bind fb_image_supervisor fb_image_props #(.SCAN_CYCLES(SCAN_CYCLES)) props_u (
  .clk_sys, .srst, .bus_in_addr, .bus_in_data, .safety_estop_n,
  .safety, .link_state, .link_error, .history_pulse, .scan_tick
);

// ===== testbench/plc_model.sv
`timescale 1ns/1ps
module plc_model (
  input wire logic clk_sys,
  input wire logic link_up,
  output logic data_exchange_active,
  output logic bus_out_we,
  output logic [5:0] bus_out_addr,
  output logic [7:0] bus_out_data,
  output logic [5:0] bus_in_addr,
  input wire logic [7:0] bus_in_data
);
  // exchange indication follows the cable state
  assign data_exchange_active = link_up;
  initial begin
    bus_out_we = 1'h0;
    bus_out_addr = 6'h00;
    bus_out_data = 8'h00;
    bus_in_addr = 6'h00;
  end
  // one byte write into the master output area
  task automatic put(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_out_we <= 1'h1;
    bus_out_addr <= a;
    bus_out_data <= d;
    @(posedge clk_sys);
    bus_out_we <= 1'h0;
    bus_out_data <= ~d; // released data does not keep its value
  endtask
  // one byte read from the master input area
  task automatic get(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus_in_addr <= a;
    repeat (3) @(posedge clk_sys);
    #1 d = bus_in_data;
  endtask
endmodule

// ===== testbench/tb_fb_image_supervisor.sv
`timescale 1ns/1ps
module tb_fb_image_supervisor import fb_image_pkg::*;;
  localparam int SC = 20;
  logic clk_sys = 1'h0;
  logic srst = 1'h1;
  logic link_up = 1'h0;
  logic data_exchange_active, bus_out_we;
  logic [5:0] bus_out_addr, bus_in_addr;
  logic [7:0] bus_out_data, bus_in_data, bit_rdata, bit_wdata = 8'h00;
  logic [3:0] word_idx = 4'h0, bit_idx = 4'h0;
  logic word_we = 1'h0, word_re = 1'h0, bit_we = 1'h0, bit_re = 1'h0;
  logic [15:0] word_wdata = 16'h0000, word_rdata;
  logic [31:0] dword_rdata;
  logic word_err, servo_enable, link_error, history_pulse, scan_tick;
  logic internal_access = 1'h1, safety_estop_n = 1'h1, safe_mode = 1'h0;
  logic parallel_interlock_input = 1'h0, safety_service = 1'h0;
  logic monitor_24v_valid = 1'h0, servo_on_req = 1'h0;
  safety_s safety;
  link_state_e link_state;
  int errors = 0, total_checks = 0, seed = 48, hist_cnt = 0;
  bit up = 0;
  logic [7:0] iimg [48], oimg [48];
  fb_image_supervisor #(.SCAN_CYCLES(SC), .WAIT_CYCLES(100)) dut_u (
    .clk_sys, .srst, .data_exchange_active, .bus_out_we, .bus_out_addr,
    .bus_out_data, .bus_in_addr, .bus_in_data, .word_idx, .word_we,
    .word_wdata, .word_re, .word_rdata, .dword_rdata, .word_err, .bit_idx,
    .bit_we, .bit_wdata, .bit_re, .bit_rdata, .internal_access,
    .safety_estop_n, .parallel_interlock_input, .safety_service,
    .monitor_24v_valid, .safe_mode, .servo_on_req, .safety, .servo_enable,
    .link_state, .link_error, .history_pulse, .scan_tick
  );
  plc_model plc_u (
    .clk_sys, .link_up, .data_exchange_active, .bus_out_we, .bus_out_addr,
    .bus_out_data, .bus_in_addr, .bus_in_data
  );
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  // noise on pins that the checked outputs do not depend on
  always @(posedge clk_sys) begin
    {safe_mode, safety_service, servo_on_req} <= 3'($random(seed));
    parallel_interlock_input <= 1'($random(seed));
  end
  // count history entries
  always @(posedge clk_sys) if (history_pulse === 1'h1) hist_cnt++;
  task automatic close_out;
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e,
                     input string n);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wst(input link_state_e s);
    for (int i = 0; i < 300 && link_state !== s; i++) tk(1);
    chk(link_state, s, "state");
  endtask
  // robot word write as two strobes, high byte first, then bit byte write
  task automatic wr(input int k, input logic [15:0] d, input logic [7:0] b);
    @(posedge clk_sys);
    word_idx <= 4'(k);
    bit_idx <= 4'(k);
    word_wdata <= d;
    bit_wdata <= b;
    word_we <= 1'h1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk(word_err, (k < 2) && !internal_access, "word err");
    @(posedge clk_sys);
    word_we <= 1'h0;
    bit_we <= (k < 14);
    @(posedge clk_sys);
    bit_we <= 1'h0;
    if (k > 1 || internal_access) begin
      {oimg[2*k], oimg[2*k+1]} = d;
      if (k < 14) oimg[32+k] = b;
    end
  endtask
  // robot word read as two strobes, then bit byte read
  task automatic rd(input int k);
    @(posedge clk_sys);
    word_idx <= 4'(k);
    bit_idx <= 4'(k);
    word_re <= 1'h1;
    repeat (2) @(posedge clk_sys);
    word_re <= 1'h0;
    bit_re <= (k < 14);
    @(posedge clk_sys);
    bit_re <= 1'h0;
    tk(3);
    chk(word_rdata, {iimg[2*k], iimg[2*k+1]}, "word");
    if (k % 2 == 1)
      chk(dword_rdata, {iimg[2*k], iimg[2*k+1], iimg[2*k-2], iimg[2*k-1]},
          "dword");
    if (k < 14) chk(bit_rdata, iimg[32+k], "bits");
  endtask
  task automatic bput(input int a, input logic [7:0] d);
    plc_u.put(6'(a), d);
    if (up && a < 46) iimg[a] = d;
  endtask
  task automatic bget(input int a);
    logic [7:0] d;
    plc_u.get(6'(a), d);
    chk(d, (up && a < 46) ? oimg[a] : 8'h00, "bus");
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    srst <= 1'h0;
    tk(1);
    chk(servo_enable, 1'h0, "servo");
    tk(60);
    chk(link_state, ST_WAIT, "wait");
    wst(ST_PWR_FAIL);
    tk(3);
    chk(hist_cnt, 1, "hist");
    chk(safety.estop_n, 1'h1, "pfail stop");
    chk(safety.interlock_n, 1'h1, "ilk");
    link_up <= 1'h1;
    wst(ST_NORMAL);
    up = 1;
    for (int k = 0; k < 16; k++) begin
      wr(k, 16'($random(seed)), 8'($random(seed)));
      bput(2*k, 8'($random(seed)));
      bput(2*k+1, 8'($random(seed)));
      if (k < 14) bput(32+k, 8'($random(seed)));
    end
    bput(46, 8'ha5);
    chk(word_err, 1'h0, "err");
    tk(2*SC+5);
    for (int k = 0; k < 16; k++) begin
      rd(k);
      bget(2*k);
      bget(2*k+1);
      if (k < 14) bget(32+k);
    end
    bget(46);
    bget(47);
    internal_access <= 1'h0;
    wr(0, 16'h1234, 8'h56);
    tk(2*SC+5);
    bget(0);
    bget(32);
    for (int v = 0; v < 2; v++) begin
      bput(32, 8'(v));
      tk(2*SC+5);
      chk(safety.estop_n, v[0], "bus stop");
    end
    safety_estop_n <= 1'h0;
    tk(10);
    chk(safety.estop_n, 1'h0, "pin stop");
    safety_estop_n <= 1'h1;
    link_up <= 1'h0;
    up = 0;
    wst(ST_LOST);
    tk(3);
    chk(hist_cnt, 2, "hist");
    chk(safety.estop_n, 1'h0, "lost stop");
    chk(safety.service, 1'h0, "lost svc");
    bput(8, 8'h5a);
    bget(2);
    link_up <= 1'h1;
    wst(ST_NORMAL);
    up = 1;
    tk(2*SC+5);
    rd(4);
    close_out;
  end
  // the whole sequence takes about a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    close_out;
  end
endmodule
